// ==== imb_pkg.sv ====
/*
 * Package for the interrupt mask bank: register offsets, reset values,
 * field positions and the carrier structs shared by the bank and its users.
 * Assumes an 8-bit register space reached through the serial register port.
 */
package imb_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] IMB_EVENT_WAKE_IRQ_MASK_OFS = 8'h56;
    localparam logic [7:0] IMB_SUPPLY_THERMAL_IRQ_MASK_OFS = 8'h57;
    localparam logic [7:0] IMB_ERROR_FAILSAFE_IRQ_MASK_OFS = 8'h58;
    localparam logic [7:0] IMB_BUS_FAULT_IRQ_MASK_OFS = 8'h59;
    localparam logic [7:0] IMB_RESERVED_IRQ_FIRST_OFS = 8'h5a;
    localparam logic [7:0] IMB_RESERVED_IRQ_LAST_OFS = 8'h5f;

    // ------------------------------------------------------------------
    // Reset values and writable-bit masks
    // ------------------------------------------------------------------
    localparam logic [7:0] IMB_EVENT_WAKE_RESET = 8'hff;
    localparam logic [7:0] IMB_SUPPLY_THERMAL_RESET = 8'h1f;
    localparam logic [7:0] IMB_ERROR_FAILSAFE_RESET = 8'ha0;
    localparam logic [7:0] IMB_BUS_FAULT_RESET = 8'h7f;
    localparam logic [7:0] IMB_RESERVED_READ = 8'h00;
    localparam logic [7:0] IMB_SUPPLY_THERMAL_WMASK = 8'h1f;
    localparam logic [7:0] IMB_ERROR_FAILSAFE_WMASK = 8'he0;
    localparam logic [7:0] IMB_BUS_FAULT_WMASK = 8'h7f;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int IMB_WATCHDOG_EVENT_BIT = 7;
    localparam int IMB_BUS_WAKEUP_BIT = 6;
    localparam int IMB_LOCAL_WAKE_BIT = 5;
    localparam int IMB_WAKE_ERROR_BIT = 4;
    localparam int IMB_FRAME_COUNTER_OVERFLOW_BIT = 3;
    localparam int IMB_BUS_SILENCE_BIT = 2;
    localparam int IMB_BUS_TIMEOUT_BIT = 1;
    localparam int IMB_STUCK_DOMINANT_BIT = 0;
    localparam int IMB_SERIAL_PORT_ERROR_BIT = 7;
    localparam int IMB_SELECTIVE_WAKE_ERROR_BIT = 6;
    localparam int IMB_FAILSAFE_ENTRY_BIT = 5;

    // ------------------------------------------------------------------
    // Carrier types: one byte per mask or flag register, and the decoded register request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] event_wake;
        logic [7:0] supply_thermal;
        logic [7:0] error_failsafe;
        logic [7:0] bus_fault;
    } imb_irq_bytes_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } imb_reg_req_t;

endpackage

// ==== imb_interrupt_mask_bank.sv ====
/*
 * Interrupt mask bank: four mask registers, a reserved block that reads
 * zero, the live selective-wake error status and the gated interrupt line.
 * Assumes the serial port delivers decoded one-cycle register requests on
 * clk, and that the flag registers sit outside and feed their levels in.
 */
// Function
// - Bit 7 of the first mask enables the watchdog event interrupt and resets to one.
// - Bits 6 and 5 of the first mask enable bus wake-up and local wake-up, both resetting to one.
// - Bits 4 and 3 of the first mask enable wake error and frame counter overflow, resetting to one.
// - Bits 2, 1 and 0 of the first mask enable bus silence, bus timeout and stuck dominant, resetting to one.
// - The second mask holds the five supply and thermal enables at bits 4..0, all resetting to one, upper bits zero.
// - Bit 7 of the third mask enables the serial-port error interrupt and resets to one.
// - Bit 6 of the third mask enables the selective-wake error interrupt and resets to zero.
// - Bit 5 of the third mask enables fail-safe entry, resets to one, and bits 4..0 read zero.
// - Bits 6..3 of the bus-fault mask enable termination open, lines shorted, high-to-battery and low-to-ground.
// - Bits 2..0 of the bus-fault mask enable bus open, ground short and battery short, and bit 7 reads zero.
// - After reset the masks read ff, 1f, a0 and, for the bus-fault mask, 7f.
// - The reserved range reads all zero and ignores writes.
// - Watchdog and bus-fault masks exist only with diagnostics, selective-wake masks only with selective wake.
// - A flag is cleared by writing one to it, and writing zero leaves it alone.
// - The selective-wake error flag is live, the OR of unconfigured enable and frame overflow, and blocks enabling.
`timescale 1ns/1ns

module imb_interrupt_mask_bank
#(
    parameter bit HAS_WATCHDOG_DIAG = 1'b1,
    parameter bit HAS_SELECTIVE_WAKE = 1'b1
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire imb_pkg::imb_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire imb_pkg::imb_irq_bytes_t flags,
    input wire logic sw_enable_req,
    input wire logic sw_config_valid,
    input wire logic frame_ovf_flag,
    output logic selective_wake_error_flag,
    output logic sw_enable,
    output imb_pkg::imb_irq_bytes_t masks,
    output logic irq
);
    import imb_pkg::*;

    // ------------------------------------------------------------------
    // Variant masks
    // ------------------------------------------------------------------
    // Bits absent on a variant are held at zero and cannot be written.
    localparam logic [7:0] EV_PRESENT = {HAS_WATCHDOG_DIAG, 3'b111, HAS_SELECTIVE_WAKE, 3'b111};
    localparam logic [7:0] EF_PRESENT = {1'b1, HAS_SELECTIVE_WAKE, 6'h3f};
    localparam logic [7:0] BF_PRESENT = {8{HAS_WATCHDOG_DIAG}};

    imb_irq_bytes_t mask_q;
    imb_irq_bytes_t mask_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic irq_q;
    logic irq_d;
    logic sw_enable_q;
    logic sw_enable_d;
    imb_irq_bytes_t eff_flags;

    // Reserved-range decode, used only by the assertions
    function automatic logic is_reserved(input logic [7:0] a);
        is_reserved = (a >= IMB_RESERVED_IRQ_FIRST_OFS) && (a <= IMB_RESERVED_IRQ_LAST_OFS);
    endfunction

    // ------------------------------------------------------------------
    // Mask register writes
    // ------------------------------------------------------------------
    // Plain read/write masks; reserved bits are forced to zero on write
    always_comb
    begin
        mask_d = mask_q;
        if (reg_req.wr_en && reg_req.addr == IMB_EVENT_WAKE_IRQ_MASK_OFS)
        begin
            mask_d.event_wake = reg_req.wdata & EV_PRESENT;
        end
        else if (reg_req.wr_en && reg_req.addr == IMB_SUPPLY_THERMAL_IRQ_MASK_OFS)
        begin
            mask_d.supply_thermal = reg_req.wdata & IMB_SUPPLY_THERMAL_WMASK;
        end
        else if (reg_req.wr_en && reg_req.addr == IMB_ERROR_FAILSAFE_IRQ_MASK_OFS)
        begin
            mask_d.error_failsafe = reg_req.wdata & IMB_ERROR_FAILSAFE_WMASK & EF_PRESENT;
        end
        else if (reg_req.wr_en && reg_req.addr == IMB_BUS_FAULT_IRQ_MASK_OFS)
        begin
            mask_d.bus_fault = reg_req.wdata & IMB_BUS_FAULT_WMASK & BF_PRESENT;
        end
        // Reserved range and other addresses: no state changes
    end

    // Reset values, trimmed to the variant
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mask_q.event_wake <= IMB_EVENT_WAKE_RESET & EV_PRESENT;
            mask_q.supply_thermal <= IMB_SUPPLY_THERMAL_RESET;
            mask_q.error_failsafe <= IMB_ERROR_FAILSAFE_RESET & EF_PRESENT;
            mask_q.bus_fault <= IMB_BUS_FAULT_RESET & BF_PRESENT;
        end
        else
        begin
            mask_q <= mask_d;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Registered answer one cycle after the request
    always_comb
    begin
        rvalid_d = reg_req.rd_en;
        rdata_d = rdata_q;
        if (reg_req.rd_en)
        begin
            if (reg_req.addr == IMB_EVENT_WAKE_IRQ_MASK_OFS)
            begin
                rdata_d = mask_q.event_wake;
            end
            else if (reg_req.addr == IMB_SUPPLY_THERMAL_IRQ_MASK_OFS)
            begin
                rdata_d = mask_q.supply_thermal;
            end
            else if (reg_req.addr == IMB_ERROR_FAILSAFE_IRQ_MASK_OFS)
            begin
                rdata_d = mask_q.error_failsafe;
            end
            else if (reg_req.addr == IMB_BUS_FAULT_IRQ_MASK_OFS)
            begin
                rdata_d = mask_q.bus_fault;
            end
            else
            begin
                rdata_d = IMB_RESERVED_READ;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ------------------------------------------------------------------
    // Selective-wake error status and interrupt gating
    // ------------------------------------------------------------------
    // Live status, not sticky: it cannot be cleared while its cause stands
    assign selective_wake_error_flag = HAS_SELECTIVE_WAKE &&
        ((sw_enable_req && !sw_config_valid) || frame_ovf_flag);

    // The live error replaces the incoming bit so the line follows it
    always_comb
    begin
        eff_flags = flags;
        eff_flags.error_failsafe[IMB_SELECTIVE_WAKE_ERROR_BIT] = selective_wake_error_flag;
        // Masks only gate the line; flags set and clear by write-one outside
        irq_d = |(eff_flags & mask_q);
        sw_enable_d = sw_enable_req && !selective_wake_error_flag;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_q <= 1'b0;
            sw_enable_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_d;
            sw_enable_q <= sw_enable_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign masks = mask_q;
    assign irq = irq_q;
    assign sw_enable = sw_enable_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_RESET_VALUES: assert property ($rose(resetn) |-> mask_q.supply_thermal == IMB_SUPPLY_THERMAL_RESET
        && mask_q.event_wake == (IMB_EVENT_WAKE_RESET & EV_PRESENT)
        && mask_q.error_failsafe == (IMB_ERROR_FAILSAFE_RESET & EF_PRESENT)
        && mask_q.bus_fault == (IMB_BUS_FAULT_RESET & BF_PRESENT))
        else $error("masks not at reset values after reset");
    AST_EV_WRITE: assert property (reg_req.wr_en && reg_req.addr == IMB_EVENT_WAKE_IRQ_MASK_OFS
        |=> mask_q.event_wake == ($past(reg_req.wdata) & EV_PRESENT))
        else $error("event wake mask write not stored");
    AST_ST_RSVD_ZERO: assert property (mask_q.supply_thermal[7:5] == 3'b000)
        else $error("supply mask reserved bits set");
    AST_EF_RSVD_ZERO: assert property (mask_q.error_failsafe[4:0] == 5'h00)
        else $error("error mask reserved bits set");
    AST_BF_RSVD_ZERO: assert property (mask_q.bus_fault[7] == 1'b0)
        else $error("bus fault mask bit 7 set");
    AST_RSVD_READ: assert property (reg_req.rd_en && is_reserved(reg_req.addr)
        |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("reserved range did not read zero");
    AST_RSVD_WRITE: assert property (reg_req.wr_en && is_reserved(reg_req.addr) && !reg_req.rd_en
        |=> $stable(mask_q))
        else $error("reserved write changed a mask");
    AST_MASK_READBACK: assert property (reg_req.rd_en && reg_req.addr == IMB_BUS_FAULT_IRQ_MASK_OFS
        |=> reg_rdata == $past(mask_q.bus_fault))
        else $error("bus fault mask read mismatch");
    AST_IRQ_GATING: assert property (|(eff_flags & mask_q) |=> irq)
        else $error("interrupt missing for enabled flag");
    AST_IRQ_QUIET: assert property (!(|(eff_flags & mask_q)) |=> !irq)
        else $error("interrupt without enabled flag");
    AST_SW_BLOCKED: assert property (selective_wake_error_flag |=> !sw_enable)
        else $error("selective wake enabled during error");
    // Absent bits must stay zero on every variant, not only after reset
    AST_VARIANT: assert property ((mask_q.event_wake & ~EV_PRESENT) == 8'h00
        && (mask_q.error_failsafe & ~EF_PRESENT) == 8'h00
        && (mask_q.bus_fault & ~BF_PRESENT) == 8'h00)
        else $error("diagnostic mask present on variant without it");

    COV_EV_WRITE: cover property (reg_req.wr_en && reg_req.addr == 8'h56 ##1 reg_req.rd_en);
    COV_IRQ_RISE: cover property (!irq ##1 irq);
    COV_SW_ERROR: cover property (sw_enable_req && selective_wake_error_flag);
    COV_RSVD_READ: cover property (reg_req.rd_en && is_reserved(reg_req.addr));

endmodule

// ==== imb_host_model.sv ====
/*
 * Host model for the interrupt mask bank: issues decoded register writes
 * and reads. Assumes it shares clk with the bank and launches requests
 * just after a rising edge.
 */
`timescale 1ns/1ns

module imb_host_model
(
    input wire logic clk,
    output imb_pkg::imb_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    import imb_pkg::*;

    // Idle port from time zero
    initial reg_req = '0;

    // One-cycle write; lines scrambled after release so nothing stale looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        reg_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask

    // One-cycle read, answer awaited for a bounded number of cycles
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        reg_req <= '{1'b0, 1'b0, ~a, 8'h5a};
        for (int i = 0; i < 4 && !ok; i++)
        begin
            @(negedge clk);
            if (reg_rvalid === 1'b1)
            begin
                ok = 1'b1;
                d = reg_rdata;
            end
        end
    endtask
endmodule

// ==== tb_interrupt_mask_bank.sv ====
/*
 * Self-checking bench for the interrupt mask bank against a byte model.
 * Assumes the full variant for the main bank, checks a reduced-variant bank beside it, and uses the host model as register master.
 */
`timescale 1ns/1ns

module tb_interrupt_mask_bank;
    import imb_pkg::*;
    localparam logic [7:0] RST [4] = '{8'hff, 8'h1f, 8'ha0, 8'h7f};
    localparam logic [7:0] WM [4] = '{8'hff, 8'h1f, 8'he0, 8'h7f};
    // Reduced variant: no watchdog, frame overflow, selective-wake or bus-fault enables
    localparam logic [31:0] VARIANT_MASKS = {8'h77, 8'h1f, 8'ha0, 8'h00};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    imb_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    imb_irq_bytes_t flags = '0;
    logic sw_enable_req = 1'b0;
    logic sw_config_valid = 1'b0;
    logic frame_ovf_flag = 1'b0;
    logic selective_wake_error_flag;
    logic sw_enable;
    logic irq;
    imb_irq_bytes_t masks;
    imb_irq_bytes_t masks_v;
    int mismatches = 0;
    int n_checks = 0;
    logic [7:0] m [4];
    logic [7:0] rv;
    bit ok;

    // 100 MHz clock
    always #5 clk = ~clk;

    imb_interrupt_mask_bank dut_u (.clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .flags(flags), .sw_enable_req(sw_enable_req), .sw_config_valid(sw_config_valid),
        .frame_ovf_flag(frame_ovf_flag), .selective_wake_error_flag(selective_wake_error_flag),
        .sw_enable(sw_enable), .masks(masks), .irq(irq));
    imb_host_model host_u (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // Second bank built as the reduced variant, sharing the same register traffic
    imb_interrupt_mask_bank #(.HAS_WATCHDOG_DIAG(1'b0), .HAS_SELECTIVE_WAKE(1'b0)) variant_u (.clk(clk),
        .resetn(resetn), .reg_req(reg_req), .reg_rdata(), .reg_rvalid(), .flags(flags),
        .sw_enable_req(sw_enable_req), .sw_config_valid(sw_config_valid), .frame_ovf_flag(frame_ovf_flag),
        .selective_wake_error_flag(), .sw_enable(), .masks(masks_v), .irq());

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Model view of the register space: only 56..59 hold state
    function automatic logic [7:0] mread(input logic [7:0] a);
        return (a >= 8'h56 && a <= 8'h59) ? m[2'(a - 8'h56)] : 8'h00;
    endfunction

    function automatic logic mirq();
        imb_irq_bytes_t f;
        f = flags;
        f.error_failsafe[6] = (sw_enable_req & ~sw_config_valid) | frame_ovf_flag;
        return |(f & {m[0], m[1], m[2], m[3]});
    endfunction

    // Masked write into the model; reserved bits never stick
    task automatic wr_m(input logic [7:0] a, input logic [7:0] d);
        host_u.wr(a, d);
        if (a >= 8'h56 && a <= 8'h59)
            m[2'(a - 8'h56)] = d & WM[2'(a - 8'h56)];
    endtask

    task automatic rd_chk(input logic [7:0] a);
        host_u.rd(a, rv, ok);
        if (!ok)
        begin
            mismatches++;
            close_out();
        end
        else
            chk("rdata", rv, mread(a));
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int k;
        logic [7:0] a;
        logic swe;
        void'($urandom(52));
        foreach (m[i]) m[i] = RST[i];
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 8'h54; i <= 8'h5f; i++)
        begin
            rd_chk(8'(i));
        end
        chk("masks", masks, {m[0], m[1], m[2], m[3]});
        chk("variant masks", masks_v, VARIANT_MASKS);
        $display("test reset values done");
        repeat (30)
        begin
            a = 8'h54 + 8'($urandom_range(0, 11));
            wr_m(a, 8'($urandom));
            rd_chk(a);
        end
        chk("masks", masks, {m[0], m[1], m[2], m[3]});
        $display("test random writes done");
        for (int i = 0; i < 4; i++) wr_m(8'h56 + 8'(i), 8'hff);
        // Last write lands on this edge; look once it has settled
        @(negedge clk);
        chk("variant masks", masks_v, VARIANT_MASKS);
        // Each flag alone, gated on then masked off; masking must drop the line
        for (int b = 0; b < 32; b++)
        begin
            k = 3 - b / 8;
            @(posedge clk);
            flags <= 32'h1 << b;
            settle();
            chk("irq on", irq, mirq());
            wr_m(8'h56 + 8'(k), m[k] & ~(8'h01 << (b % 8)));
            settle();
            chk("irq masked", irq, 1'b0);
            wr_m(8'h56 + 8'(k), 8'hff);
        end
        @(posedge clk);
        flags <= '0;
        $display("test interrupt gating done");
        for (int c = 0; c < 8; c++)
        begin
            @(posedge clk);
            {sw_enable_req, sw_config_valid, frame_ovf_flag} <= 3'(c);
            @(negedge clk);
            // Expected error worked out from the inputs alone
            swe = (sw_enable_req & ~sw_config_valid) | frame_ovf_flag;
            chk("sw error", selective_wake_error_flag, swe);
            @(negedge clk);
            chk("sw enable", sw_enable, sw_enable_req & ~swe);
            @(negedge clk);
            chk("irq sw", irq, mirq());
        end
        $display("test selective wake done");
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        foreach (m[i]) m[i] = RST[i];
        for (int i = 8'h56; i <= 8'h59; i++) rd_chk(8'(i));
        $display("test second reset done");
        close_out();
    end
endmodule
